// >>> src/fosb_pkg.sv
package fosb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;

  // Command register fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_OP_LSB   = 8;
  localparam int CMD_GUARD    = 10;
  localparam int CMD_CLEARS   = 11;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_POLL  = 2'h2;

  // Status byte bit positions
  localparam int BIT_IDLE      = 7;
  localparam int BIT_ERASE_SUS = 6;
  localparam int BIT_ERASE_ERR = 5;
  localparam int BIT_PROG_ERR  = 4;
  localparam int BIT_PIN_ERR   = 3;
  localparam int BIT_PROG_SUS  = 2;
  localparam int BIT_PROT_ERR  = 1;
  localparam logic [7:0] ERR_MASK     = 8'h3a;
  localparam logic [7:0] RESERVED_MSK = 8'hfe;

  // Failure causes reported to software
  localparam logic [2:0] CAUSE_NONE      = 3'h0;
  localparam logic [2:0] CAUSE_ERASE_MAX = 3'h1;
  localparam logic [2:0] CAUSE_PROG_MAX  = 3'h2;
  localparam logic [2:0] CAUSE_PIN       = 3'h3;
  localparam logic [2:0] CAUSE_PROT      = 3'h4;
  localparam logic [2:0] CAUSE_SEQ       = 3'h5;

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_ACC_NS      = 90;
  localparam int T_WP_NS       = 70;
  localparam int ACC_CYC_I     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC_I      = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ACC_CYC = 4'(ACC_CYC_I);
  localparam logic [3:0] WP_CYC  = 4'(WP_CYC_I);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_WPULSE = 3'b010,
    ST_WHOLD  = 3'b011,
    ST_RDWAIT = 3'b100,
    ST_RGAP   = 3'b101,
    ST_DONE   = 3'b110
  } fosb_state_t;

endpackage : fosb_pkg

// >>> src/fosb_status_decode.sv
`timescale 1ns/1ns
module fosb_status_decode
  import fosb_pkg::*;
(
  // Sampled byte
  input  wire logic [7:0] status,
  // Decoded view
  output logic            idle,
  output logic            erase_susp,
  output logic            prog_susp,
  output logic            err_any,
  output logic [2:0]      cause
);

  logic erase_err;
  logic prog_err;

  assign idle       = status[BIT_IDLE];
  // Other bits are meaningless while the controller works
  assign erase_susp = idle & status[BIT_ERASE_SUS];
  assign prog_susp  = idle & status[BIT_PROG_SUS];
  assign err_any    = idle & |(status & ERR_MASK);
  assign erase_err  = status[BIT_ERASE_ERR];
  assign prog_err   = status[BIT_PROG_ERR];

  // Erase-suspend bit is ignored here so D0h..F0h decode like 90h..B0h
  always_comb begin
    cause = CAUSE_NONE;
    if (!idle) begin
      cause = CAUSE_NONE;
    end else if (erase_err && prog_err) begin
      cause = CAUSE_SEQ;
    end else if (status[BIT_PIN_ERR]) begin
      cause = CAUSE_PIN;
    end else if (status[BIT_PROT_ERR]) begin
      cause = CAUSE_PROT;
    end else if (erase_err) begin
      cause = CAUSE_ERASE_MAX;
    end else if (prog_err) begin
      cause = CAUSE_PROG_MAX;
    end
  end

endmodule : fosb_status_decode

// >>> src/fosb_host.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module fosb_host
  import fosb_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Flash pins
  output logic                   flash_ce_b,
  output logic                   flash_oe_b,
  output logic                   flash_we_b,
  output logic      [ADDR_W-1:0] flash_addr,
  input  wire logic [7:0]        flash_dq_in,
  output logic      [7:0]        flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   program_erase_enable_pin
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  function automatic logic fosb_mapped(input logic [7:0] a);
    return (a == OFF_CMD) || (a == OFF_ADDR) || (a == OFF_STATUS) || (a == OFF_CONFIG);
  endfunction : fosb_mapped

  fosb_state_t       state_r;
  fosb_state_t       state_nxt;
  logic [3:0]        cnt_r;
  logic [1:0]        op_r;
  logic              clears_r;
  logic [7:0]        data_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        status_r;
  logic              err_seen_r;
  logic              refused_r;
  logic              pe_pin_r;
  logic [31:0]       prdata_r;
  logic              busy;
  logic              setup_ph;
  logic              wr_acc;
  logic              cmd_wr;
  logic              refuse;
  logic              start;
  logic              rd_last;
  logic              sample;
  logic              dec_idle;
  logic              dec_erase_susp;
  logic              dec_prog_susp;
  logic              dec_err_any;
  logic [2:0]        dec_cause;

  assign busy     = (state_r != ST_IDLE);
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign cmd_wr   = wr_acc & (paddr == OFF_CMD);
  // New guarded command refused while an old error is still unread-cleared
  assign refuse   = cmd_wr & ~busy & pwdata[CMD_GUARD] & err_seen_r;
  assign start    = cmd_wr & ~busy & ~refuse;
  assign rd_last  = (state_r == ST_RDWAIT) && (cnt_r == ACC_CYC - 4'h1);
  assign sample   = rd_last;

  // Zero wait states; a command written while busy is answered with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~fosb_mapped(paddr) | (cmd_wr & busy));
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r   <= '0;
      pe_pin_r <= 1'b0;
    end else if (wr_acc && paddr == OFF_ADDR && !busy) begin
      addr_r <= pwdata[ADDR_W-1:0];
    end else if (wr_acc && paddr == OFF_CONFIG) begin
      pe_pin_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_r     <= OP_WRITE;
      clears_r <= 1'b0;
      data_r   <= 8'h00;
    end else if (start) begin
      op_r     <= pwdata[CMD_OP_LSB +: 2];
      clears_r <= pwdata[CMD_CLEARS];
      data_r   <= pwdata[CMD_DATA_LSB +: 8];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refused_r <= 1'b0;
    end else if (refuse) begin
      refused_r <= 1'b1;
    end else if (start) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      unique case (paddr)
        OFF_ADDR:   prdata_r <= 32'(addr_r);
        OFF_STATUS: prdata_r <= {15'h0000, dec_cause, dec_prog_susp, dec_erase_susp,
                                 dec_idle, err_seen_r, refused_r, busy, status_r};
        OFF_CONFIG: prdata_r <= {31'h0000_0000, pe_pin_r};
        default:    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= STATUS_RST;
    end else if (sample) begin
      status_r <= flash_dq_in & RESERVED_MSK;
    end
  end

  // Host copy of the sticky flags; only a finished clear-status drops it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_seen_r <= 1'b0;
    end else if (sample && flash_dq_in[BIT_IDLE] && |(flash_dq_in & ERR_MASK)) begin
      err_seen_r <= 1'b1;
    end else if (state_r == ST_DONE && clears_r) begin
      err_seen_r <= 1'b0;
    end
  end

  fosb_status_decode u_decode (
    .status     (status_r),
    .idle       (dec_idle),
    .erase_susp (dec_erase_susp),
    .prog_susp  (dec_prog_susp),
    .err_any    (dec_err_any),
    .cause      (dec_cause)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (start) state_nxt = ST_SETUP;
      ST_SETUP:  state_nxt = (op_r == OP_WRITE) ? ST_WPULSE : ST_RDWAIT;
      ST_WPULSE: if (cnt_r == WP_CYC - 4'h1) state_nxt = ST_WHOLD;
      ST_WHOLD:  state_nxt = ST_DONE;
      ST_RDWAIT: begin
        if (rd_last) begin
          // Busy answer: raise OE for a cycle so the next read is fresh
          if (op_r == OP_POLL && !flash_dq_in[BIT_IDLE]) begin
            state_nxt = ST_RGAP;
          end else begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_RGAP:   state_nxt = ST_RDWAIT;
      ST_DONE:   state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (state_nxt != state_r) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Strobes decoded from state flops; one level of gating, no feedback
  assign flash_ce_b   = (state_r == ST_IDLE) || (state_r == ST_DONE);
  assign flash_oe_b   = (state_r != ST_RDWAIT);
  assign flash_we_b   = (state_r != ST_WPULSE);
  assign flash_dq_oe  = (state_r == ST_WPULSE) || (state_r == ST_WHOLD);
  assign flash_dq_out = data_r;
  assign flash_addr   = addr_r;
  assign program_erase_enable_pin = pe_pin_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_mask_low: assert property (@(posedge clk) disable iff (!rst_b)
    status_r[0] == 1'b0) else $error("reserved status bit not masked");

  a_poll_toggle: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_last && op_r == OP_POLL && !flash_dq_in[BIT_IDLE])
      |=> flash_oe_b && !flash_ce_b ##1 !flash_oe_b) else $error("poll read not refreshed");

  a_poll_finish: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_DONE && op_r == OP_POLL) |-> status_r[BIT_IDLE])
    else $error("poll ended while controller busy");

  a_access_time: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(flash_oe_b) |-> (!flash_oe_b)[*2]) else $error("read access too short");

  a_guard_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    refuse |=> refused_r && state_r == ST_IDLE ##1 flash_we_b)
    else $error("guarded command issued over error");

  a_clear_errors: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_DONE && clears_r && !sample) |=> !err_seen_r)
    else $error("error copy not cleared");

  a_susp_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !status_r[BIT_IDLE] |-> !dec_erase_susp && !dec_prog_susp && dec_cause == CAUSE_NONE)
    else $error("suspend flags trusted while busy");

  a_no_contend: assert property (@(posedge clk) disable iff (!rst_b)
    !flash_oe_b |-> !flash_dq_oe && flash_we_b) else $error("bus contention");

  // Deselect after every write so the next select brings a fresh status byte
  a_deselect: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_WHOLD) |=> flash_ce_b && flash_we_b && !flash_dq_oe ##1 !busy)
    else $error("chip not deselected after write");

  a_err_copy: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(dec_err_any) |-> err_seen_r) else $error("error flags not copied");

  a_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
    (psel && penable && !fosb_mapped(paddr)) |-> pslverr) else $error("unmapped not flagged");

endmodule : fosb_host

// >>> tb/fosb_flash_model.sv
`timescale 1ns/1ns
module fosb_flash_model #(
  parameter logic [7:0] CLR_CODE   = 8'h50,
  parameter int         BUSY_READS = 2
) (
  // Control pins
  input  wire logic       ce_b,
  input  wire logic       oe_b,
  input  wire logic       we_b,
  input  wire logic       pe_pin,
  // Data lines
  input  wire logic [7:0] dq_in,
  output logic      [7:0] dq_drv,
  output logic            dq_en
);
  logic [7:0] stat_r;
  logic [7:0] junk_r;
  int         busy_r;

  initial begin
    stat_r = 8'h80;
    junk_r = 8'h5a;
    busy_r = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command bytes: the written byte stands for the outcome the bench wants
  always @(posedge we_b) begin
    if (!ce_b) begin
      if (dq_in == CLR_CODE) begin
        stat_r <= 8'h80;
      end else begin
        busy_r <= BUSY_READS;
        if (!pe_pin) stat_r <= 8'h98 | (stat_r & 8'h3a);
        else stat_r <= 8'h80 | (dq_in & 8'h46) | ((dq_in | stat_r) & 8'h3a);
      end
    end
  end

  // Only an output enable edge refreshes the byte, so a held read stays stale
  always @(negedge oe_b) begin
    junk_r <= ~junk_r + 8'h01;
    if (!ce_b && busy_r > 0) busy_r <= busy_r - 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign dq_en = !ce_b && !oe_b;
  always_comb begin
    if (!dq_en) dq_drv = junk_r;
    else if (busy_r > 0) dq_drv = {1'b0, junk_r[6:0]};
    else dq_drv = {stat_r[7:1], junk_r[0]};
  end
endmodule : fosb_flash_model

// >>> tb/flash_operation_status_byte_tb_top.sv
`timescale 1ns/1ns
module flash_operation_status_byte_tb_top;
  import fosb_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_r;
  logic        pready, pslverr, err_r, ce_b, oe_b, we_b, dq_oe, pe_pin, m_en;
  logic [21:0] faddr, a;
  logic [7:0]  dq_out, m_dq, dq_in;
  logic [15:0] rnd = 16'd20707;
  int          bad_count = 0, checks = 0, cyc = 0, n;
  logic [7:0]  codes [15] = '{8'h80, 8'hc0, 8'h84, 8'hc4, 8'ha0, 8'h90, 8'hb0, 8'h98,
                              8'h92, 8'hf0, 8'hd8, 8'hd2, 8'hd0, 8'ha2, 8'ha8};

  // Undriven lines show the inverse of the last byte, so a stray sample shows up
  assign dq_in = dq_oe ? dq_out : m_en ? m_dq : ~m_dq;
  always #25 clk = ~clk;

  fosb_host i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b),
    .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .program_erase_enable_pin(pe_pin));
  fosb_flash_model i_mem (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .pe_pin(pe_pin),
    .dq_in(dq_in), .dq_drv(m_dq), .dq_en(m_en));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Refused bit is left out of the word; it is checked on its own
  function automatic logic [31:0] exp_stat(input logic [7:0] s, input logic seen);
    logic [2:0] c;
    case (s & 8'h3a)
      8'h20:        c = CAUSE_ERASE_MAX;
      8'h10:        c = CAUSE_PROG_MAX;
      8'h30:        c = CAUSE_SEQ;
      8'h28, 8'h18: c = CAUSE_PIN;
      8'h22, 8'h12: c = CAUSE_PROT;
      default:      c = CAUSE_NONE;
    endcase
    return {15'h0, c, s[2], s[6], 1'b1, seen, 2'b00, s & RESERVED_MSK};
  endfunction : exp_stat

  task automatic give_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_r = prdata;
    err_r = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll count tells whether busy was ever seen
  task automatic wait_idle(output int cnt);
    cnt = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      cnt++;
    end while (rd_r[8] !== 1'b0);
  endtask : wait_idle

  task automatic run(input logic [7:0] b, input logic [1:0] op, input logic g,
                     input logic c, output int cnt);
    apb(1'b1, OFF_CMD, {20'h0, c, g, op, b});
    wait_idle(cnt);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    chk({27'h0, ce_b, oe_b, we_b, dq_oe, pe_pin}, 32'h1c);
    rst_b <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd_r & 32'h1ff, {24'h0, STATUS_RST});
    apb(1'b0, OFF_CONFIG, 32'h0);
    chk(rd_r, CONFIG_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err_r}, 32'h1);
    chk(rd_r, 32'h0);
    // Enable pin still low from reset
    run(8'h80, OP_WRITE, 1'b1, 1'b0, n);
    run(8'h00, OP_POLL, 1'b0, 1'b0, n);
    chk(rd_r & ~32'h200, exp_stat(8'h98, 1'b1));
    apb(1'b1, OFF_CONFIG, 32'h1);
    foreach (codes[i]) begin
      rnd = lfsr(rnd);
      a = {rnd[5:0], rnd};
      apb(1'b1, OFF_ADDR, {10'h0, a});
      apb(1'b0, OFF_ADDR, 32'h0);
      chk(rd_r, {10'h0, a});
      chk({10'h0, faddr}, {10'h0, a});
      run(8'h50, OP_WRITE, 1'b0, 1'b1, n);
      run(codes[i], OP_WRITE, 1'b1, 1'b0, n);
      chk(32'(n > 1), 32'h1);
      run(8'h00, OP_POLL, 1'b0, 1'b0, n);
      chk(rd_r & ~32'h200, exp_stat(codes[i], |(codes[i] & ERR_MASK)));
    end
    // Back-to-back command while busy
    apb(1'b1, OFF_CMD, 32'h80);
    apb(1'b1, OFF_CMD, 32'h80);
    chk({31'h0, err_r}, 32'h1);
    wait_idle(n);
    // Single read while the flash is still busy: flags must not be trusted
    run(8'h00, OP_READ, 1'b0, 1'b0, n);
    chk(rd_r & 32'h1f800, 32'h0);
    run(8'h00, OP_POLL, 1'b0, 1'b0, n);
    chk(rd_r & ~32'h200, exp_stat(8'ha8, 1'b1));
    run(8'h80, OP_WRITE, 1'b1, 1'b0, n);
    chk({30'h0, rd_r[9], n == 1}, 32'h3);
    run(8'h50, OP_WRITE, 1'b0, 1'b1, n);
    run(8'h00, OP_POLL, 1'b0, 1'b0, n);
    chk(rd_r & ~32'h200, exp_stat(8'h80, 1'b0));
    give_verdict;
  end
endmodule : flash_operation_status_byte_tb_top
